// ==== shared/fcp_pkg.sv ====
`default_nettype none
package fcp_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int ADDR_W = 14;
  localparam int DATA_W = 8;
  localparam int WB_ADR_W = 16;
  localparam int WB_DAT_W = 32;
  localparam int PAGE_LSB = 6;
  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [15:0] OFS_OPT_SHADOW = 16'h0210;
  localparam logic [15:0] OFS_NONVOLATILE_OPTION_BYTE = 16'h3FFC;
  localparam logic [15:0] OFS_FLASH_CTRL = 16'h0214;
  localparam logic [15:0] OFS_WIN_SEL = 16'h0218;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_SECURITY = 0;
  localparam int BIT_HIGH_VOLTAGE_ENABLE = 3;
  localparam int BIT_MASS = 2;
  localparam int BIT_PGM = 0;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic RST_SECURITY_CODE = 1'b0;
  localparam logic RST_CTRL_BIT = 1'b0;
  localparam logic [7:0] RST_WIN_SEL = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // ----------------------------------------
  // Address map constants
  // ----------------------------------------
  localparam logic [7:0] WIN_PAGE = 8'h03;
  localparam logic [13:0] IDX_DATA_ADDR = 14'h000E;
  localparam logic [5:0] IDX_PAD = 6'h00;
  localparam logic [13:0] FLASH_LO_DEF = 14'h3C00;
  // ----------------------------------------
  // Program and erase sequence tracking
  // ----------------------------------------
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_SELECT,
    SEQ_ARMED,
    SEQ_HV
  } fcp_seq_type;
endpackage
`default_nettype wire

// ==== shared/fcp_map_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Logical to physical address mapping carrier
interface fcp_map_if;
  logic [13:0] log_addr;
  logic [7:0] index_x;
  logic [7:0] page;
  logic [13:0] phys_addr;
  logic in_window;
  logic via_index;
  modport requester (
    output log_addr,
    output index_x,
    output page,
    input phys_addr,
    input in_window,
    input via_index
  );
  modport mapper (
    input log_addr,
    input index_x,
    input page,
    output phys_addr,
    output in_window,
    output via_index
  );
endinterface // fcp_map_if
`default_nettype wire

// ==== src/fcp_window_map.sv ====
`timescale 1ns/1ps
`default_nettype none
module fcp_window_map (
  // Mapping carrier
  fcp_map_if.mapper m
);
  logic [13:0] eff;

  // Indexed data first, then the paging window on the result
  always_comb begin
    eff = m.log_addr;
    m.via_index = 1'b0;
    if (m.log_addr == fcp_pkg::IDX_DATA_ADDR) begin
      // One level only, so X holding the same address reaches the RAM cell
      eff = {fcp_pkg::IDX_PAD, m.index_x};
      m.via_index = 1'b1;
    end
    m.in_window = (eff[13:fcp_pkg::PAGE_LSB] == fcp_pkg::WIN_PAGE);
    if (m.in_window) begin
      m.phys_addr = {m.page, eff[fcp_pkg::PAGE_LSB-1:0]};
    end else begin
      m.phys_addr = eff;
    end
  end
endmodule // fcp_window_map
`default_nettype wire

// ==== src/fcp_flash_ctrl.sv ====
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
`default_nettype none
module fcp_flash_ctrl #(
  parameter logic [13:0] FLASH_LO = fcp_pkg::FLASH_LO_DEF
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Stored option byte from the array
  input wire logic [7:0] nonvolatile_option_byte_data,
  // CPU direct page access
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic [13:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_from_debug,
  input wire logic [7:0] index_x,
  input wire logic debug_pin_enable,
  output logic [7:0] cpu_rdata,
  output logic cpu_rvalid,
  // Physical memory side
  output logic mem_req,
  output logic mem_we,
  output logic [13:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  // Array controls
  output logic program_select,
  output logic mass_erase_select,
  output logic high_voltage_enable,
  output logic security_engaged
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic wb_ack_ff;
  logic [31:0] wb_dat_ff;
  logic load_pend_ff;
  logic security_code_bit_ff;
  logic pgm_ff;
  logic mass_ff;
  logic high_voltage_enable_ff;
  logic nxt_pgm;
  logic nxt_mass;
  logic nxt_high_voltage_enable;
  logic [7:0] window_block_select_ff;
  fcp_pkg::fcp_seq_type seq_ff;
  fcp_pkg::fcp_seq_type nxt_seq;
  logic bus_req;
  logic bus_wr;
  logic hit_shadow;
  logic hit_nonvolatile_option_byte;
  logic hit_ctrl;
  logic hit_win;
  logic ctrl_wr;
  logic [7:0] wr_byte;
  logic [7:0] rd_byte;
  logic secured;
  logic is_flash;
  logic rd_blocked;
  logic flash_write;
  logic mem_req_ff;
  logic mem_we_ff;
  logic [13:0] mem_addr_ff;
  logic [7:0] mem_wdata_ff;
  logic rd_pend_ff;
  logic rd_zero_ff;
  logic [7:0] cpu_rdata_ff;
  logic cpu_rvalid_ff;
  logic prog_ff;
  logic mass_out_ff;
  logic hv_out_ff;
  logic sec_out_ff;

  fcp_map_if map_if ();

  // ----------------------------------------
  // Address mapping
  // ----------------------------------------

  // Window and indexed data translation lives in its own module
  assign map_if.log_addr = cpu_addr;
  assign map_if.index_x = index_x;
  assign map_if.page = window_block_select_ff;

  fcp_window_map u_map (
    .m(map_if.mapper)
  );

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------

  // Requests wait until the option byte is in place
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_ff & ~load_pend_ff;
  assign bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  assign hit_shadow = (wb_adr_i == fcp_pkg::OFS_OPT_SHADOW);
  assign hit_nonvolatile_option_byte = (wb_adr_i == fcp_pkg::OFS_NONVOLATILE_OPTION_BYTE);
  assign hit_ctrl = (wb_adr_i == fcp_pkg::OFS_FLASH_CTRL);
  assign hit_win = (wb_adr_i == fcp_pkg::OFS_WIN_SEL);
  assign ctrl_wr = bus_wr & hit_ctrl;
  assign wr_byte = wb_dat_i[7:0];

  // Single cycle answer, dropped in the following cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      wb_ack_ff <= 1'b0;
    end else begin
      wb_ack_ff <= bus_req;
    end
  end

  // ----------------------------------------
  // Option shadow
  // ----------------------------------------

  // Reset parks the shadow in the secure state, the copy follows release
  always_ff @(posedge mclk) begin
    if (srst) begin
      load_pend_ff <= 1'b1;
      security_code_bit_ff <= fcp_pkg::RST_SECURITY_CODE;
    end else if (load_pend_ff) begin
      load_pend_ff <= 1'b0;
      security_code_bit_ff <= nonvolatile_option_byte_data[fcp_pkg::BIT_SECURITY];
    end
  end
  // No write path reaches the shadow at all

  assign secured = ~security_code_bit_ff;

  // ----------------------------------------
  // Flash control bits
  // ----------------------------------------

  // Next values with the select interlock and security gate
  always_comb begin
    nxt_pgm = pgm_ff;
    nxt_mass = mass_ff;
    nxt_high_voltage_enable = high_voltage_enable_ff;
    if (ctrl_wr) begin
      // A write asking for both selects leaves them as they were
      if (!(wr_byte[fcp_pkg::BIT_PGM] && wr_byte[fcp_pkg::BIT_MASS])) begin
        nxt_mass = wr_byte[fcp_pkg::BIT_MASS];
        if (!secured) begin
          nxt_pgm = wr_byte[fcp_pkg::BIT_PGM];
        end
        if (nxt_pgm && nxt_mass) begin
          nxt_pgm = pgm_ff;
          nxt_mass = mass_ff;
        end
      end
      if (!wr_byte[fcp_pkg::BIT_HIGH_VOLTAGE_ENABLE]) begin
        nxt_high_voltage_enable = 1'b0;
      // A select cleared by the same write cannot switch voltage on; voltage already on stays on
      end else if ((pgm_ff || mass_ff) && (nxt_pgm || nxt_mass) &&
                   (seq_ff == fcp_pkg::SEQ_ARMED)) begin
        nxt_high_voltage_enable = 1'b1;
      end
    end
  end

  // Control register, cleared by reset so nothing is in progress
  always_ff @(posedge mclk) begin
    if (srst) begin
      pgm_ff <= fcp_pkg::RST_CTRL_BIT;
      mass_ff <= fcp_pkg::RST_CTRL_BIT;
      high_voltage_enable_ff <= fcp_pkg::RST_CTRL_BIT;
    end else begin
      pgm_ff <= nxt_pgm;
      mass_ff <= nxt_mass;
      high_voltage_enable_ff <= nxt_high_voltage_enable;
    end
  end

  // ----------------------------------------
  // Sequence tracking
  // ----------------------------------------

  // A latching write into flash through the window arms the voltage step
  assign flash_write = cpu_req & cpu_we & map_if.in_window & is_flash;

  // Timing waits are the software's job; only the order is enforced here
  always_comb begin
    nxt_seq = seq_ff;
    unique case (seq_ff)
      fcp_pkg::SEQ_IDLE: begin
        if (pgm_ff || mass_ff) begin
          nxt_seq = fcp_pkg::SEQ_SELECT;
        end
      end
      fcp_pkg::SEQ_SELECT: begin
        if (!(pgm_ff || mass_ff)) begin
          nxt_seq = fcp_pkg::SEQ_IDLE;
        end else if (flash_write) begin
          nxt_seq = fcp_pkg::SEQ_ARMED;
        end
      end
      fcp_pkg::SEQ_ARMED: begin
        if (!(pgm_ff || mass_ff)) begin
          nxt_seq = fcp_pkg::SEQ_IDLE;
        end else if (high_voltage_enable_ff) begin
          nxt_seq = fcp_pkg::SEQ_HV;
        end
      end
      fcp_pkg::SEQ_HV: begin
        // Voltage may drop before or after the select is cleared
        if (!high_voltage_enable_ff) begin
          nxt_seq = (pgm_ff || mass_ff) ? fcp_pkg::SEQ_SELECT : fcp_pkg::SEQ_IDLE;
        end
      end
    endcase
  end

  // Sequence state register
  always_ff @(posedge mclk) begin
    if (srst) begin
      seq_ff <= fcp_pkg::SEQ_IDLE;
    end else begin
      seq_ff <= nxt_seq;
    end
  end

  // ----------------------------------------
  // Window block select
  // ----------------------------------------

  // Full byte becomes address bits thirteen to six
  always_ff @(posedge mclk) begin
    if (srst) begin
      window_block_select_ff <= fcp_pkg::RST_WIN_SEL;
    end else if (bus_wr && hit_win) begin
      window_block_select_ff <= wr_byte;
    end
  end

  // ----------------------------------------
  // Register read back
  // ----------------------------------------

  // Unmapped addresses answer zero; unused bits read zero, the window select returns its full byte
  always_comb begin
    rd_byte = fcp_pkg::BYTE_ZERO;
    if (hit_shadow) begin
      rd_byte[fcp_pkg::BIT_SECURITY] = security_code_bit_ff;
    end else if (hit_nonvolatile_option_byte) begin
      rd_byte[fcp_pkg::BIT_SECURITY] = nonvolatile_option_byte_data[fcp_pkg::BIT_SECURITY];
    end else if (hit_ctrl) begin
      rd_byte[fcp_pkg::BIT_HIGH_VOLTAGE_ENABLE] = high_voltage_enable_ff;
      rd_byte[fcp_pkg::BIT_MASS] = mass_ff;
      rd_byte[fcp_pkg::BIT_PGM] = pgm_ff;
    end else if (hit_win) begin
      rd_byte = window_block_select_ff;
    end
  end

  // Read data is captured with the answer
  always_ff @(posedge mclk) begin
    if (srst) begin
      wb_dat_ff <= '0;
    end else if (bus_req) begin
      wb_dat_ff <= {24'h000000, rd_byte};
    end
  end

  // ----------------------------------------
  // CPU access path
  // ----------------------------------------

  assign is_flash = (map_if.phys_addr >= FLASH_LO);

  // Debug side reads of a secured array never reach the memory
  assign rd_blocked = secured & is_flash & ~cpu_we & (cpu_from_debug | debug_pin_enable);

  // One cycle memory strobe with the translated address
  always_ff @(posedge mclk) begin
    if (srst) begin
      mem_req_ff <= 1'b0;
      mem_we_ff <= 1'b0;
      mem_addr_ff <= '0;
      mem_wdata_ff <= fcp_pkg::BYTE_ZERO;
    end else begin
      mem_req_ff <= cpu_req & ~rd_blocked;
      if (cpu_req) begin
        mem_we_ff <= cpu_we;
        mem_addr_ff <= map_if.phys_addr;
        mem_wdata_ff <= cpu_wdata;
      end
    end
  end

  // Read tracking one cycle ahead of the returned byte
  always_ff @(posedge mclk) begin
    if (srst) begin
      rd_pend_ff <= 1'b0;
      rd_zero_ff <= 1'b0;
    end else begin
      rd_pend_ff <= cpu_req & ~cpu_we;
      rd_zero_ff <= rd_blocked;
    end
  end

  // Blocked reads still complete, so the requester never hangs
  always_ff @(posedge mclk) begin
    if (srst) begin
      cpu_rdata_ff <= fcp_pkg::BYTE_ZERO;
      cpu_rvalid_ff <= 1'b0;
    end else begin
      cpu_rvalid_ff <= rd_pend_ff;
      if (rd_pend_ff) begin
        cpu_rdata_ff <= rd_zero_ff ? fcp_pkg::BYTE_ZERO : mem_rdata;
      end
    end
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------

  // Array controls mirror the control register, and security_engaged the inverse of the security shadow, one cycle later
  always_ff @(posedge mclk) begin
    if (srst) begin
      prog_ff <= fcp_pkg::RST_CTRL_BIT;
      mass_out_ff <= fcp_pkg::RST_CTRL_BIT;
      hv_out_ff <= fcp_pkg::RST_CTRL_BIT;
      sec_out_ff <= ~fcp_pkg::RST_SECURITY_CODE;
    end else begin
      prog_ff <= pgm_ff;
      mass_out_ff <= mass_ff;
      hv_out_ff <= high_voltage_enable_ff;
      sec_out_ff <= secured;
    end
  end

  assign wb_ack_o = wb_ack_ff;
  assign wb_dat_o = wb_dat_ff;
  assign cpu_rdata = cpu_rdata_ff;
  assign cpu_rvalid = cpu_rvalid_ff;
  assign mem_req = mem_req_ff;
  assign mem_we = mem_we_ff;
  assign mem_addr = mem_addr_ff;
  assign mem_wdata = mem_wdata_ff;
  assign program_select = prog_ff;
  assign mass_erase_select = mass_out_ff;
  assign high_voltage_enable = hv_out_ff;
  assign security_engaged = sec_out_ff;

endmodule // fcp_flash_ctrl
`default_nettype wire

// ==== testbench/fcp_flash_ctrl_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----
// Port checker
// ----
module fcp_flash_ctrl_sva #(
  parameter logic [13:0] FLASH_LO = 14'h3C00
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // CPU side
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic [13:0] cpu_addr,
  input wire logic cpu_from_debug,
  input wire logic [7:0] index_x,
  input wire logic cpu_rvalid,
  input wire logic [7:0] cpu_rdata,
  // Memory and array
  input wire logic mem_req,
  input wire logic [13:0] mem_addr,
  input wire logic program_select,
  input wire logic mass_erase_select,
  input wire logic high_voltage_enable,
  input wire logic security_engaged
);
  // One clock domain, so one clocking and one disable
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |-> ##[1:2] wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer late or long");
  property p_excl;
    !(program_select && mass_erase_select);
  endproperty
  a_excl: assert property (p_excl) else $error("both selects set");
  property p_hv;
    $rose(high_voltage_enable) |-> program_select || mass_erase_select;
  endproperty
  a_hv: assert property (p_hv) else $error("high voltage without select");
  property p_pgm;
    $rose(program_select) |-> !security_engaged;
  endproperty
  a_pgm: assert property (p_pgm) else $error("program select while secured");
  property p_block;
    cpu_req && !cpu_we && cpu_from_debug && security_engaged && cpu_addr >= FLASH_LO
      |=> !mem_req ##1 cpu_rvalid && cpu_rdata == 8'h00;
  endproperty
  a_block: assert property (p_block) else $error("secure read leaked");
  property p_win;
    cpu_req && cpu_we && cpu_addr[13:6] == 8'h03
      |=> mem_req && mem_addr[5:0] == $past(cpu_addr[5:0]);
  endproperty
  a_win: assert property (p_win) else $error("window offset lost");
  property p_out;
    cpu_req && cpu_we && cpu_addr[13:6] != 8'h03 && cpu_addr != 14'h000E
      |=> mem_addr == $past(cpu_addr);
  endproperty
  a_out: assert property (p_out) else $error("plain address remapped");
  property p_idx;
    cpu_req && cpu_addr == 14'h000E && index_x < 8'hC0
      |=> mem_addr == {6'h00, $past(index_x)};
  endproperty
  a_idx: assert property (p_idx) else $error("indexed access misrouted");
  // Main scenarios reached
  c_prog: cover property (high_voltage_enable && program_select);
  c_mass: cover property (high_voltage_enable && mass_erase_select);
  c_sec: cover property (cpu_rvalid && security_engaged);
endmodule // fcp_flash_ctrl_sva
`default_nettype wire

// ==== testbench/fcp_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----
// Memory behind the block
// ----
module fcp_mem_model (
  // Clock
  input wire logic mclk,
  // Physical memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [13:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem_ff [16384];
  logic [7:0] last_ff = 8'h00;
  // Known fill so every read is predictable
  initial begin
    for (int i = 0; i < 16384; i++) begin
      mem_ff[i] = 8'(i) ^ 8'h5A;
    end
  end
  // Write port; idle value keeps changing
  always @(posedge mclk) begin
    if (mem_req && mem_we) begin
      mem_ff[mem_addr] <= mem_wdata;
    end
    last_ff <= mem_rdata;
  end
  // Idle shows the inverse, never a stale copy
  assign mem_rdata = mem_req ? mem_ff[mem_addr] : ~last_ff;
endmodule // fcp_mem_model
`default_nettype wire

// ==== testbench/flash_control_and_paging_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----
// Bench top
// ----
module flash_control_and_paging_tb;
  logic mclk = 1'b0, srst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [15:0] wb_adr_i = 16'h0000;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h00000000, wb_dat_o;
  logic cpu_req = 1'b0, cpu_we = 1'b0, cpu_from_debug = 1'b0, debug_pin_enable = 1'b0;
  logic [7:0] nonvolatile_option_byte_data = 8'h00, cpu_wdata = 8'h00, index_x = 8'h00, sel_m = 8'h00;
  logic [13:0] cpu_addr = 14'h0000, mem_addr, pa;
  logic [7:0] cpu_rdata, mem_wdata, mem_rdata, q;
  logic wb_ack_o, cpu_rvalid, mem_req, mem_we, program_select, mass_erase_select;
  logic high_voltage_enable, security_engaged;
  logic [7:0] wr_m [int];
  int n_fail = 0, n_compared = 0;
  // Clock, 50 ns period
  always #25 mclk = ~mclk;
  fcp_flash_ctrl dut (.mclk(mclk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .nonvolatile_option_byte_data(nonvolatile_option_byte_data), .cpu_req(cpu_req),
    .cpu_we(cpu_we), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .index_x(index_x),
    .cpu_from_debug(cpu_from_debug), .debug_pin_enable(debug_pin_enable),
    .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .program_select(program_select), .mass_erase_select(mass_erase_select),
    .high_voltage_enable(high_voltage_enable), .security_engaged(security_engaged));
  fcp_mem_model u_mem (.mclk(mclk), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  // Verdict, the only way out
  task automatic tally_and_finish;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t data %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_adr(input logic [13:0] g, input logic [13:0] e);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t address %h want %h", $time, g, e);
    end
  endtask
  // Classic cycle: hold until ack is sampled, then release
  task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20) begin
      n_fail++;
      tally_and_finish();
    end
  endtask
  task automatic rg(input logic [15:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk_reg(q, e);
  endtask
  task automatic ctl(input logic [7:0] w, input logic [7:0] e);
    wb(1'b1, 16'h0214, w);
    rg(16'h0214, e);
  endtask
  task automatic sel(input logic [7:0] s);
    wb(1'b1, 16'h0218, s);
    sel_m = s;
    rg(16'h0218, s);
  endtask
  // One-cycle request; address seen in the next cycle, data one later
  task automatic cpu(input logic w, input logic [13:0] a, input logic [7:0] d);
    @(posedge mclk);
    cpu_req <= 1'b1;
    cpu_we <= w;
    cpu_addr <= a;
    cpu_wdata <= d;
    @(posedge mclk);
    cpu_req <= 1'b0;
    @(posedge mclk);
    pa = mem_addr;
    if (!w) begin
      @(posedge mclk);
      chk_reg({7'h00, cpu_rvalid}, 8'h01);
      q = cpu_rdata;
    end
  endtask
  // Reference mapping: indexed slot first, then the window
  function automatic logic [13:0] phys(input logic [13:0] a);
    logic [13:0] p;
    p = (a == 14'h000E) ? {6'h00, index_x} : a;
    if (p[13:6] == 8'h03) p = {sel_m, p[5:0]};
    return p;
  endfunction
  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    cpu(1'b1, a, d);
    chk_adr(pa, phys(a));
    chk_reg(mem_wdata, d);
    chk_reg({7'h00, mem_we}, 8'h01);
    wr_m[phys(a)] = d;
  endtask
  task automatic rd(input logic [13:0] a);
    logic [13:0] p;
    cpu(1'b0, a, 8'h00);
    p = phys(a);
    chk_adr(pa, p);
    chk_reg(q, wr_m.exists(p) ? wr_m[p] : p[7:0] ^ 8'h5A);
  endtask
  // Main sequence
  initial begin
    void'($urandom(43272));
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    rg(16'h0210, 8'h00);
    chk_reg({7'h00, security_engaged}, 8'h01);
    rg(16'h0214, 8'h00);
    rg(16'h0218, 8'h00);
    rg(16'h0300, 8'h00);
    wb(1'b1, 16'h0210, 8'hFF);
    rg(16'h0210, 8'h00);
    ctl(8'h01, 8'h00);
    ctl(8'h04, 8'h04);
    cpu_from_debug <= 1'b1;
    cpu(1'b0, 14'h3C05, 8'h00);
    chk_reg(q, 8'h00);
    cpu_from_debug <= 1'b0;
    debug_pin_enable <= 1'b1;
    cpu(1'b0, 14'h3FC1, 8'h00);
    chk_reg(q, 8'h00);
    debug_pin_enable <= 1'b0;
    // Erased option byte, then a fresh reset
    nonvolatile_option_byte_data <= 8'hFF;
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    rg(16'h0210, 8'h01);
    rg(16'h3FFC, 8'h01);
    chk_reg({7'h00, security_engaged}, 8'h00);
    rg(16'h0214, 8'h00);
    sel(8'hF0);
    ctl(8'h05, 8'h00);
    ctl(8'h01, 8'h01);
    chk_reg({7'h00, program_select}, 8'h01);
    ctl(8'h09, 8'h01);
    wr(14'h00C3, 8'h3C);
    ctl(8'h09, 8'h09);
    chk_reg({7'h00, high_voltage_enable}, 8'h01);
    wr(14'h00C4, 8'h96);
    ctl(8'h08, 8'h08);
    ctl(8'h00, 8'h00);
    ctl(8'h04, 8'h04);
    chk_reg({7'h00, mass_erase_select}, 8'h01);
    wr(14'h00C0, 8'h11);
    ctl(8'h0C, 8'h0C);
    ctl(8'h08, 8'h08);
    ctl(8'h00, 8'h00);
    sel(8'h08);
    rd(14'h00D0);
    sel(8'h00);
    rd(14'h00CF);
    rd(14'h00CE);
    index_x <= 8'h0E;
    rd(14'h000E);
    index_x <= 8'hCE;
    rd(14'h000E);
    wr(14'h0020, 8'h5C);
    for (int i = 0; i < 8; i++) begin
      sel(8'($urandom()));
      index_x <= 8'($urandom());
      cpu_from_debug <= 1'($urandom());
      wr(14'h00C0 + 14'($urandom() % 64), 8'($urandom()));
      rd(14'h00C0 + 14'($urandom() % 64));
      rd(14'($urandom() % 256));
    end
    tally_and_finish();
  end
endmodule // flash_control_and_paging_tb
bind fcp_flash_ctrl fcp_flash_ctrl_sva #(.FLASH_LO(FLASH_LO)) u_sva (.mclk(mclk),
  .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_addr(cpu_addr), .cpu_from_debug(cpu_from_debug),
  .index_x(index_x), .cpu_rvalid(cpu_rvalid), .cpu_rdata(cpu_rdata), .mem_req(mem_req),
  .mem_addr(mem_addr), .program_select(program_select), .mass_erase_select(mass_erase_select),
  .high_voltage_enable(high_voltage_enable), .security_engaged(security_engaged));
`default_nettype wire
